// *** hdl/mftmio_defs.svh ***
// Register offsets, field positions, mode codes and reset values of the timer mode and I/O block
`ifndef MFTMIO_DEFS_SVH
`define MFTMIO_DEFS_SVH

`define MFTMIO_OFF_MODE0 8'h00
`define MFTMIO_OFF_MODE1 8'h04
`define MFTMIO_OFF_MODE2 8'h08
`define MFTMIO_OFF_MODE3 8'h0c
`define MFTMIO_OFF_MODE4 8'h10
`define MFTMIO_OFF_IOCTL4 8'h14
`define MFTMIO_OFF_GENB4 8'h18
`define MFTMIO_OFF_CNT4 8'h1c
`define MFTMIO_OFF_STATUS 8'h20

`define MFTMIO_IOB_LO 4
`define MFTMIO_IOB_HI 7

`define MFTMIO_MD_NORMAL 4'h0
`define MFTMIO_MD_PWM1 4'h2
`define MFTMIO_MD_PWM2 4'h3
`define MFTMIO_MD_PHASE1 4'h4
`define MFTMIO_MD_PHASE2 4'h5
`define MFTMIO_MD_PHASE3 4'h6
`define MFTMIO_MD_PHASE4 4'h7
`define MFTMIO_MD_RSPWM 4'h8
`define MFTMIO_MD_CPWM1 4'hd
`define MFTMIO_MD_CPWM2 4'he
`define MFTMIO_MD_CPWM3 4'hf

`define MFTMIO_RST_MODE 4'h0
`define MFTMIO_RST_IOCTL 8'h00
`define MFTMIO_RST_GENB 16'h0000

`define MFTMIO_RESP_OKAY 2'b00
`define MFTMIO_RESP_SLVERR 2'b10

`endif

// *** hdl/mftmio_pkg.sv ***
// Types shared by the timer mode and I/O block
package mftmio_pkg;
  typedef enum logic [10:0] {
    MODE_NORMAL = 11'h001,
    MODE_PWM1 = 11'h002,
    MODE_PWM2 = 11'h004,
    MODE_PHASE1 = 11'h008,
    MODE_PHASE2 = 11'h010,
    MODE_PHASE3 = 11'h020,
    MODE_PHASE4 = 11'h040,
    MODE_RSPWM = 11'h080,
    MODE_CPWM1 = 11'h100,
    MODE_CPWM2 = 11'h200,
    MODE_CPWM3 = 11'h400
  } mftmio_mode_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } mftmio_bus_t;
endpackage

// *** hdl/mftmio_mode_decode.sv ***
// Decoder of one channel's operating-mode field into a mode and a legality flag
`timescale 1ns/10ps
`default_nettype none
`include "mftmio_defs.svh"

module mftmio_mode_decode #(
  parameter int CHANNEL = 0
) (
  // Field
  input wire logic [3:0] modeSel,
  // Result
  output mftmio_pkg::mftmio_mode_t mode,
  output logic legal
);
  always_comb
  begin
    mode = mftmio_pkg::MODE_NORMAL;
    legal = 1'b1;
    case (modeSel)
      `MFTMIO_MD_NORMAL: mode = mftmio_pkg::MODE_NORMAL; // R1
      `MFTMIO_MD_PWM1: mode = mftmio_pkg::MODE_PWM1; // R1
      `MFTMIO_MD_PWM2:
      begin
        mode = mftmio_pkg::MODE_PWM2; // R1
        legal = (CHANNEL != 3) && (CHANNEL != 4); // R4
      end
      `MFTMIO_MD_PHASE1, `MFTMIO_MD_PHASE2, `MFTMIO_MD_PHASE3, `MFTMIO_MD_PHASE4:
      begin
        mode = (modeSel == `MFTMIO_MD_PHASE1) ? mftmio_pkg::MODE_PHASE1 :
               (modeSel == `MFTMIO_MD_PHASE2) ? mftmio_pkg::MODE_PHASE2 :
               (modeSel == `MFTMIO_MD_PHASE3) ? mftmio_pkg::MODE_PHASE3 :
               mftmio_pkg::MODE_PHASE4; // R2
        legal = (CHANNEL == 1) || (CHANNEL == 2); // R5
      end
      `MFTMIO_MD_RSPWM:
      begin
        mode = mftmio_pkg::MODE_RSPWM; // R3
        legal = (CHANNEL == 3); // R6 R8
      end
      `MFTMIO_MD_CPWM1, `MFTMIO_MD_CPWM2, `MFTMIO_MD_CPWM3:
      begin
        mode = (modeSel == `MFTMIO_MD_CPWM1) ? mftmio_pkg::MODE_CPWM1 :
               (modeSel == `MFTMIO_MD_CPWM2) ? mftmio_pkg::MODE_CPWM2 :
               mftmio_pkg::MODE_CPWM3; // R3
        legal = (CHANNEL == 3); // R6 R8
      end
      default:
      begin
        // Prohibited codes fall back to normal counting
        mode = mftmio_pkg::MODE_NORMAL;
        legal = 1'b0; // R1 R3
      end
    endcase
  end
endmodule
`default_nettype wire

// *** hdl/mftmio_pin_ctrl.sv ***
// Compare-output and capture-edge logic for the channel 4 B pin
`timescale 1ns/10ps
`default_nettype none
`include "mftmio_defs.svh"

module mftmio_pin_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic [3:0] ioCtl,
  input wire logic ioLoad,
  input wire logic compareMatch,
  input wire logic pinSync,
  // Results
  output logic pinOut,
  output logic pinOe,
  output logic captureEvent
);
  typedef struct packed {
    logic level;
    logic prevIn;
    logic primed;
  } mftmio_pin_state_t;

  mftmio_pin_state_t st, next_st;
  logic isCapture;
  logic rise;
  logic fall;

  always_comb
  begin
    next_st = st;
    isCapture = ioCtl[3]; // R9 R12
    rise = pinSync && !st.prevIn;
    fall = !pinSync && st.prevIn;
    next_st.prevIn = pinSync;
    if (!st.primed)
      next_st.primed = 1'b1;
    captureEvent = 1'b0;
    // Retain settings keep the level the pin already has
    if (ioLoad && !isCapture && (ioCtl[1:0] != 2'b00))
      next_st.level = ioCtl[2]; // R9 R10 R11
    else if (!isCapture && compareMatch)
    begin
      case (ioCtl[1:0])
        2'b00: next_st.level = st.level; // R9
        2'b01: next_st.level = 1'b0; // R9
        2'b10: next_st.level = 1'b1; // R10
        2'b11: next_st.level = !st.level; // R11
      endcase
    end
    if (isCapture && st.primed)
    begin
      case (ioCtl[1:0])
        2'b00: captureEvent = rise; // R12
        2'b01: captureEvent = fall; // R12
        default: captureEvent = rise || fall; // R12
      endcase
    end
    pinOut = st.level;
    pinOe = !isCapture;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      st <= '0; // R13
    else
      st <= next_st;
  end
endmodule
`default_nettype wire

// *** hdl/mftmio_top.sv ***
// Timer mode selection and channel 4 B pin control behind an AXI4-Lite slave
//
// How it works
// R1: 0000 normal, 0010 PWM1, 0011 PWM2; 0001 prohibited
// R2: 0100 to 0111 select phase counting 1-4
// R3: 1000 reset-sync PWM, 1101/1110/1111 complementary PWM
// R4: Software keeps PWM mode 2 off channels 3, 4
// R5: Software keeps phase counting off channels 0, 3, 4
// R6: Reset-sync and complementary PWM only on channel 3
// R7: Channel 4 follows channel 3 in those modes
// R8: Software never writes those modes into channel 4
// R9: Compare mode: 01 drives low, 00 retains output
// R10: Compare mode 10 drives pin high on match
// R11: Compare mode 11 toggles pin on match
// R12: Capture mode: 00 rising, 01 falling, 1x both
// R13: Pin drives 0 after reset until programmed
// R14: Match when counter equals general register B
`timescale 1ns/10ps
`default_nettype none
`include "mftmio_defs.svh"

module mftmio_top #(
  parameter int NUM_CH = 5,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel 4 B capture/compare pin
  input wire logic ch4_b_capture_compare_pin_in,
  output logic ch4_b_capture_compare_pin_out,
  output logic ch4_b_capture_compare_pin_oe,
  // Channel states
  output logic [NUM_CH*4-1:0] effectiveMode,
  output logic compareMatch4b,
  output logic captureEvent4b
);
  typedef struct packed {
    logic [NUM_CH-1:0][3:0] modeSel;
    logic [7:0] ch4_io_control_high;
    logic [CNT_W-1:0] ch4_general_reg_b;
    logic [CNT_W-1:0] counter4;
    logic ioLoad;
    logic [NUM_CH-1:0] illegal;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pinMeta;
    logic pinSync;
    logic [NUM_CH*4-1:0] effMode;
    logic match;
    logic capEv;
    logic pinOut;
    logic pinOe;
    // Registered readies
    logic awReady;
    logic wReady;
    logic arReady;
  } mftmio_state_t;

  // Channel 3 leads channel 4 in the synchronous PWM modes
  localparam int CH3 = 3;
  localparam int CH4 = 4;

  mftmio_state_t st, next_st;
  mftmio_pkg::mftmio_mode_t chMode [NUM_CH];
  logic [NUM_CH-1:0] chLegal;
  logic [3:0] chEff [NUM_CH];
  logic ch3Sync;
  logic [3:0] ch4ModeEff;
  logic pinOutC;
  logic pinOeC;
  logic capEvC;
  logic matchC;
  logic doWrite;
  logic doRead;
  logic [31:0] wMask;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : g_dec
      mftmio_mode_decode #(
        .CHANNEL(g)
      ) u_dec (
        .modeSel(st.modeSel[g]),
        .mode(chMode[g]),
        .legal(chLegal[g])
      );
      // A refused code runs as normal counting rather than half-configured
      assign chEff[g] = chLegal[g] ? st.modeSel[g] : `MFTMIO_MD_NORMAL; // R1 R3 R6
    end
  endgenerate

  mftmio_pin_ctrl u_pin (
    .clock(clock),
    .nrst(nrst),
    .ioCtl(st.ch4_io_control_high[`MFTMIO_IOB_HI:`MFTMIO_IOB_LO]),
    .ioLoad(st.ioLoad),
    .compareMatch(matchC),
    .pinSync(st.pinSync),
    .pinOut(pinOutC),
    .pinOe(pinOeC),
    .captureEvent(capEvC)
  );

  always_comb
  begin
    next_st = st;
    next_st.ioLoad = 1'b0;

    // Pin passes two flops before anything looks at it
    next_st.pinMeta = ch4_b_capture_compare_pin_in;
    next_st.pinSync = st.pinMeta;

    ch3Sync = (chMode[CH3] == mftmio_pkg::MODE_RSPWM) ||
              (chMode[CH3] == mftmio_pkg::MODE_CPWM1) ||
              (chMode[CH3] == mftmio_pkg::MODE_CPWM2) ||
              (chMode[CH3] == mftmio_pkg::MODE_CPWM3); // R6
    // Channel 4 own field is ignored while channel 3 drives it
    ch4ModeEff = ch3Sync ? chEff[CH3] : chEff[CH4]; // R7
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_st.effMode[i*4 +: 4] = chEff[i];
      next_st.illegal[i] = !chLegal[i];
    end
    next_st.effMode[CH4*4 +: 4] = ch4ModeEff; // R7
    // A stray code left in channel 4 is not flagged while it is overridden
    if (ch3Sync)
      next_st.illegal[CH4] = 1'b0; // R7

    // Counter free-runs; software may reload it to place the next match
    next_st.counter4 = st.counter4 + 1'b1;
    // In capture mode register B holds a timestamp, so it must not match
    matchC = 1'b0;
    if (!st.ch4_io_control_high[`MFTMIO_IOB_HI])
      matchC = (st.counter4 == st.ch4_general_reg_b); // R14
    next_st.match = matchC;
    next_st.capEv = capEvC;
    next_st.pinOut = pinOutC;
    next_st.pinOe = pinOeC;
    // A bus write to register B in the same cycle lands after the capture and wins
    if (capEvC)
      next_st.ch4_general_reg_b = st.counter4; // R12

    // Write channel
    // Address and data may come in either order; each waits for the other
    if (s_axi_awvalid && !st.awHeld)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wHeld)
    begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    // A new write waits while its response is still pending
    doWrite = st.awHeld && st.wHeld && !st.bvalid;
    for (int b = 0; b < 4; b++)
      wMask[b*8 +: 8] = {8{st.wStrb[b]}};
    if (doWrite)
    begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `MFTMIO_RESP_OKAY;
      // Mode offsets are four bytes apart, so address bits 4:2 pick the channel
      case (st.awAddr)
        `MFTMIO_OFF_MODE0, `MFTMIO_OFF_MODE1, `MFTMIO_OFF_MODE2,
        `MFTMIO_OFF_MODE3, `MFTMIO_OFF_MODE4:
        begin
          if (st.wStrb[0])
            next_st.modeSel[st.awAddr[4:2]] = st.wData[3:0]; // R1 R2 R3
        end
        `MFTMIO_OFF_IOCTL4:
        begin
          if (st.wStrb[0])
          begin
            // The pin takes its initial level two cycles after this write lands
            next_st.ch4_io_control_high = st.wData[7:0];
            next_st.ioLoad = 1'b1; // R13
          end
        end
        `MFTMIO_OFF_GENB4:
          next_st.ch4_general_reg_b = (st.ch4_general_reg_b & ~wMask[CNT_W-1:0]) |
                                      (st.wData[CNT_W-1:0] & wMask[CNT_W-1:0]);
        // A counter write replaces this cycle's increment
        `MFTMIO_OFF_CNT4:
          next_st.counter4 = (st.counter4 & ~wMask[CNT_W-1:0]) |
                             (st.wData[CNT_W-1:0] & wMask[CNT_W-1:0]);
        // Unmapped offsets answer with an error and change nothing
        default: next_st.bresp = `MFTMIO_RESP_SLVERR;
      endcase
    end

    // Response drops once the master has taken it
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // Read channel
    // A read is answered one cycle after its address is taken
    doRead = s_axi_arvalid && !st.rvalid;
    if (doRead)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `MFTMIO_RESP_OKAY;
      next_st.rdata = 32'h00000000;
      case (s_axi_araddr)
        `MFTMIO_OFF_MODE0, `MFTMIO_OFF_MODE1, `MFTMIO_OFF_MODE2,
        `MFTMIO_OFF_MODE3, `MFTMIO_OFF_MODE4:
          next_st.rdata[3:0] = st.modeSel[s_axi_araddr[4:2]];
        `MFTMIO_OFF_IOCTL4: next_st.rdata[7:0] = st.ch4_io_control_high;
        `MFTMIO_OFF_GENB4: next_st.rdata[CNT_W-1:0] = st.ch4_general_reg_b;
        `MFTMIO_OFF_CNT4: next_st.rdata[CNT_W-1:0] = st.counter4;
        `MFTMIO_OFF_STATUS:
        begin
          // Illegal-mode flags first, then the event and live pin bits
          next_st.rdata[NUM_CH-1:0] = st.illegal;
          next_st.rdata[NUM_CH] = st.capEv;
          next_st.rdata[NUM_CH+1] = st.match;
          next_st.rdata[NUM_CH+2] = st.pinOut;
          next_st.rdata[NUM_CH+3] = st.pinSync;
        end
        default: next_st.rresp = `MFTMIO_RESP_SLVERR;
      endcase
    end
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;

    // Readies are registered copies, so every bus output leaves a flop
    next_st.awReady = !next_st.awHeld;
    next_st.wReady = !next_st.wHeld;
    next_st.arReady = !next_st.rvalid;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      st <= '0;
      st.ch4_io_control_high <= `MFTMIO_RST_IOCTL;
      st.ch4_general_reg_b <= `MFTMIO_RST_GENB;
      // Readies and pin enable come out of reset high
      st.pinOe <= 1'b1; // R13
      st.awReady <= 1'b1;
      st.wReady <= 1'b1;
      st.arReady <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Bus side
  assign s_axi_awready = st.awReady;
  assign s_axi_wready = st.wReady;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arReady;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // Timer side
  // Pin is a driven 0 straight out of reset
  assign ch4_b_capture_compare_pin_out = st.pinOut; // R13
  assign ch4_b_capture_compare_pin_oe = st.pinOe;
  assign effectiveMode = st.effMode;
  assign compareMatch4b = st.match;
  assign captureEvent4b = st.capEv;
endmodule
`default_nettype wire

// *** bench/mftmio_monitor.sv ***
// Port checks for the timer mode and I/O block
`timescale 1ns/10ps
`default_nettype none
module mftmio_monitor #(
  parameter int NUM_CH = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Pin and state
  input wire logic ch4_b_capture_compare_pin_out,
  input wire logic ch4_b_capture_compare_pin_oe,
  input wire logic [NUM_CH*4-1:0] effectiveMode,
  input wire logic compareMatch4b,
  input wire logic captureEvent4b
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  function automatic logic syncMode(input logic [3:0] m);
    return m inside {4'h8, 4'hd, 4'he, 4'hf};
  endfunction
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ch4_follow_a: assert property (syncMode(effectiveMode[15:12]) |-> effectiveMode[19:16] == effectiveMode[15:12])
    else $error("channel 4 not following channel 3");
  low_ch_a: assert property (!syncMode(effectiveMode[3:0]) && !syncMode(effectiveMode[7:4]) && !syncMode(effectiveMode[11:8]))
    else $error("sync mode on low channel");
  no_prohib_a: assert property (!(effectiveMode[15:12] inside {4'h1, 4'h9, 4'ha, 4'hb, 4'hc}))
    else $error("prohibited mode active");
  reset_pin_a: assert property ($rose(nrst) |-> !ch4_b_capture_compare_pin_out && ch4_b_capture_compare_pin_oe)
    else $error("pin not low after reset");
  cap_mode_a: assert property (captureEvent4b |-> !ch4_b_capture_compare_pin_oe)
    else $error("capture while driving");
  match_mode_a: assert property (compareMatch4b |-> ch4_b_capture_compare_pin_oe)
    else $error("match outside compare");
  cap_pulse_a: assert property (captureEvent4b |=> !captureEvent4b)
    else $error("capture pulse too long");
endmodule
`default_nettype wire

// *** bench/mftmio_pin_model.sv ***
// Far side of the channel 4 B pin: drives the line whenever the block lets go of it
`timescale 1ns/10ps
`default_nettype none
module mftmio_pin_model (
  // Pin
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic level,
  output logic pinIn
);
  // Block owns the wire while enabled, so no contention is modelled
  assign pinIn = pinOe ? pinOut : level;
endmodule
`default_nettype wire

// *** bench/tb_mftmio_top.sv ***
// Self-checking bench for the timer mode and I/O block
`timescale 1ns/10ps
`default_nettype none
`include "mftmio_defs.svh"
module tb_mftmio_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, farLevel = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic ch4_b_capture_compare_pin_in, ch4_b_capture_compare_pin_out;
  logic ch4_b_capture_compare_pin_oe, compareMatch4b, captureEvent4b;
  logic [19:0] effectiveMode;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  mftmio_top mftmio_top_i (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ch4_b_capture_compare_pin_in, .ch4_b_capture_compare_pin_out,
    .ch4_b_capture_compare_pin_oe, .effectiveMode, .compareMatch4b, .captureEvent4b);
  mftmio_pin_model mftmio_pin_model_i (.pinOut(ch4_b_capture_compare_pin_out),
    .pinOe(ch4_b_capture_compare_pin_oe), .level(farLevel), .pinIn(ch4_b_capture_compare_pin_in));
  initial
  begin
    forever #2 clock = ~clock;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      conclude;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One write at a time; bready is raised early, which the bus allows
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic testReset;
    logic [7:0] regs [3] = '{`MFTMIO_OFF_MODE0, `MFTMIO_OFF_IOCTL4, `MFTMIO_OFF_GENB4};
    logic [31:0] d;
    logic [1:0] r;
    chk({ch4_b_capture_compare_pin_out, ch4_b_capture_compare_pin_oe}, 2'b01);
    chk(effectiveMode, 20'h0);
    foreach (regs[i])
    begin
      rd(regs[i], d, r);
      chk(d, 32'h0);
    end
    $display("reset values done");
  endtask
  task automatic testModes;
    logic [3:0] e3;
    logic [1:0] r;
    for (int c = 0; c < 16; c++)
    begin
      wr(`MFTMIO_OFF_MODE1, c, r);
      waitCyc(2);
      chk(effectiveMode[7:4], (c == 1 || c > 7) ? 0 : c);
    end
    wr(`MFTMIO_OFF_MODE4, `MFTMIO_MD_PWM1, r);
    for (int c = 8; c < 16; c++)
    begin
      wr(`MFTMIO_OFF_MODE3, c, r);
      waitCyc(2);
      e3 = (c inside {8, 13, 14, 15}) ? 4'(c) : 4'h0;
      chk(effectiveMode[15:12], e3);
      chk(effectiveMode[19:16], (e3 != 4'h0) ? e3 : `MFTMIO_MD_PWM1);
    end
    wr(`MFTMIO_OFF_MODE3, 32'h0, r);
    waitCyc(2);
    chk(effectiveMode[19:16], `MFTMIO_MD_PWM1);
    $display("mode decode done");
  endtask
  task automatic testUnmapped;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h24, 32'h1, r);
    chk(r, `MFTMIO_RESP_SLVERR);
    rd(8'h24, d, r);
    chk({d, r}, {32'h0, `MFTMIO_RESP_SLVERR});
    $display("unmapped access done");
  endtask
  task automatic testCompare;
    logic [3:0] ctl [8] = '{4'h2, 4'h1, 4'h3, 4'h5, 4'h6, 4'h0, 4'h7, 4'h4};
    logic init, after, prev;
    logic [1:0] r;
    int n;
    prev = 1'b0;
    wr(`MFTMIO_OFF_GENB4, 32'h40, r);
    foreach (ctl[i])
    begin
      init = (ctl[i][1:0] == 2'b00) ? prev : ctl[i][2];
      after = ctl[i][1] ? (ctl[i][0] ? ~init : 1'b1) : (ctl[i][0] ? 1'b0 : init);
      // Counter restarts first so no match can slip in while the mode is loaded
      wr(`MFTMIO_OFF_CNT4, 32'h0, r);
      wr(`MFTMIO_OFF_IOCTL4, {24'h0, ctl[i], 4'h0}, r);
      waitCyc(2);
      chk(ch4_b_capture_compare_pin_out, init);
      n = 0;
      while (!compareMatch4b && n < 200)
      begin
        @(posedge clock);
        n++;
      end
      chk(compareMatch4b, 1'b1);
      waitCyc(4);
      chk(ch4_b_capture_compare_pin_out, after);
      prev = after;
    end
    $display("compare output done");
  endtask
  task automatic edgeAt(input logic v, input logic exp);
    int n;
    farLevel <= v;
    n = 0;
    repeat (10)
    begin
      @(posedge clock);
      n += captureEvent4b;
    end
    chk(n != 0, exp);
  endtask
  task automatic testCapture;
    logic [3:0] cap [4] = '{4'h8, 4'h9, 4'ha, 4'hc};
    logic [1:0] r;
    foreach (cap[i])
    begin
      wr(`MFTMIO_OFF_IOCTL4, {24'h0, cap[i], 4'h0}, r);
      waitCyc(2);
      chk(ch4_b_capture_compare_pin_oe, 1'b0);
      edgeAt(1'b1, cap[i][1:0] != 2'b01);
      edgeAt(1'b0, cap[i][1:0] != 2'b00);
    end
    $display("input capture done");
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    testReset;
    testModes;
    testUnmapped;
    testCompare;
    testCapture;
    conclude;
  end
endmodule
bind mftmio_top mftmio_monitor #(.NUM_CH(NUM_CH)) mftmio_monitor_i (.clock, .nrst,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .ch4_b_capture_compare_pin_out, .ch4_b_capture_compare_pin_oe,
  .effectiveMode, .compareMatch4b, .captureEvent4b);
`default_nettype wire
